// ---- logic/esd_pkg.sv ----
package esd_pkg;

  // channel layout
  localparam int unsigned NUM_CH    = 48;
  localparam int unsigned PORT_W    = 8;
  localparam int unsigned NUM_PORTS = 6;

  // clock and debounce timing
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned DEB_TICK_NS   = 1000;
  localparam int unsigned DEB_TICK_CYC  = (DEB_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DIV_W         = 5;
  localparam int unsigned DEB_CNT_W     = 11;

  // debounce lengths in ticks, one per select code
  localparam logic [DEB_CNT_W-1:0] DEB_LIM_0 = 11'h001;
  localparam logic [DEB_CNT_W-1:0] DEB_LIM_1 = 11'h008;
  localparam logic [DEB_CNT_W-1:0] DEB_LIM_2 = 11'h040;
  localparam logic [DEB_CNT_W-1:0] DEB_LIM_3 = 11'h400;

  // reset values
  localparam logic [NUM_CH-1:0] OUT_RESET  = 48'h0000_0000_0000;
  localparam logic [NUM_CH-1:0] OE_N_RESET = 48'hFFFF_FFFF_FFFF;

  // which port bank an access reaches
  typedef enum logic {
    ESD_SPACE_OUT,
    ESD_SPACE_IN
  } esd_space_type;

  // host access request
  typedef struct packed {
    logic          valid;
    logic          write;
    esd_space_type space;
    logic [2:0]    port;
    logic [3:0]    be;
    logic [31:0]   wdata;
  } esd_acc_type;

  // host access answer
  typedef struct packed {
    logic        valid;
    logic [31:0] rdata;
  } esd_rsp_type;

  // per-channel configuration, plus one debounce select shared by all channels
  typedef struct packed {
    logic [NUM_CH-1:0] dir_out;
    logic [NUM_CH-1:0] pol_rise;
    logic [NUM_CH-1:0] irq_en;
    logic [1:0]        deb_sel;
  } esd_cfg_type;

endpackage : esd_pkg

// ---- logic/esd_chan.sv ----
`timescale 1ns/1ps
`default_nettype none

module esd_chan (
  // clock and reset
  input  wire logic                          mclk_i,
  input  wire logic                          reset_n_i,
  // pin and timing
  input  wire logic                          pin_i,
  input  wire logic                          tick_i,
  input  wire logic [esd_pkg::DEB_CNT_W-1:0] deb_lim_i,
  // event control
  input  wire logic                          pol_rise_i,
  input  wire logic                          pend_clr_i,
  // status
  output logic                               filt_o,
  output logic                               pend_o
);
  import esd_pkg::*;

  typedef struct packed {
    logic                 sync1;
    logic                 sync2;
    logic                 filt;
    logic [DEB_CNT_W-1:0] cnt;
    logic                 pend;
  } esd_chan_state_type;

  esd_chan_state_type state_reg;
  esd_chan_state_type state_next;
  logic               evt;

  // sync, debounce, edge qualify, pending latch
  always_comb begin
    state_next = state_reg;
    evt        = 1'b0;
    state_next.sync1 = pin_i;
    state_next.sync2 = state_reg.sync1;
    if (state_reg.sync2 == state_reg.filt) begin
      state_next.cnt = '0;  // any bounce restarts the wait
    end else if (tick_i) begin
      if (state_reg.cnt + 11'h001 >= deb_lim_i) begin
        state_next.filt = state_reg.sync2;
        state_next.cnt  = '0;
        evt = (state_reg.sync2 == pol_rise_i);
      end else begin
        state_next.cnt = state_reg.cnt + 11'h001;
      end
    end
    // set wins over a clear in the same cycle
    state_next.pend = (state_reg.pend & ~pend_clr_i) | evt;
  end

  // reset clears the filtered level, so a line high after reset gives a rising event once debounced if its pol_rise bit is set
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign filt_o = state_reg.filt;
  assign pend_o = state_reg.pend;

endmodule : esd_chan

`default_nettype wire

// ---- logic/esd_top.sv ----
`timescale 1ns/1ps
`default_nettype none

module esd_top (
  // clock and reset
  input  wire logic                       mclk_i,
  input  wire logic                       reset_n_i,
  // host access port
  input  wire esd_pkg::esd_acc_type       acc_i,
  output esd_pkg::esd_rsp_type            rsp_o,
  // software configuration and event clear
  input  wire esd_pkg::esd_cfg_type       cfg_i,
  input  wire logic [esd_pkg::NUM_CH-1:0] pend_clr_i,
  // field pins, open drain
  input  wire logic [esd_pkg::NUM_CH-1:0] pin_i,
  output logic [esd_pkg::NUM_CH-1:0]      pin_o,
  output logic [esd_pkg::NUM_CH-1:0]      pin_oe_n_o,
  // status
  output logic [esd_pkg::NUM_CH-1:0]      filt_o,
  output logic [esd_pkg::NUM_CH-1:0]      pend_o,
  output logic                            irq_o
);
  import esd_pkg::*;

  typedef struct packed {
    logic [DIV_W-1:0]  div;
    logic              tick;
    logic [NUM_CH-1:0] out;
    logic [NUM_CH-1:0] oe_n;
    esd_rsp_type       rsp;
    logic              irq;
  } esd_top_state_type;

  esd_top_state_type    state_reg;
  esd_top_state_type    state_next;
  logic [DEB_CNT_W-1:0] deb_lim;
  logic [NUM_CH-1:0]    filt;
  logic [NUM_CH-1:0]    pend;
  logic [5:0]           base;
  logic                 port_ok;

  // debounce length from the software select
  always_comb begin
    case (cfg_i.deb_sel)
      2'h0:    deb_lim = DEB_LIM_0;
      2'h1:    deb_lim = DEB_LIM_1;
      2'h2:    deb_lim = DEB_LIM_2;
      default: deb_lim = DEB_LIM_3;
    endcase
  end

  // one channel slice per line; every line gets the full feature set
  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    esd_chan u_chan (
      .mclk_i     (mclk_i),
      .reset_n_i  (reset_n_i),
      .pin_i      (pin_i[c]),
      .tick_i     (state_reg.tick),
      .deb_lim_i  (deb_lim),
      .pol_rise_i (cfg_i.pol_rise[c]),
      .pend_clr_i (pend_clr_i[c]),
      .filt_o     (filt[c]),
      .pend_o     (pend[c])
    );
  end

  assign base    = {acc_i.port, 3'b000};
  assign port_ok = (acc_i.port < 3'(NUM_PORTS));

  // divider, host access, output drive, interrupt merge
  always_comb begin
    state_next = state_reg;
    // debounce interval tick, one cycle wide
    if (state_reg.div == DIV_W'(DEB_TICK_CYC - 1)) begin
      state_next.div  = '0;
      state_next.tick = 1'b1;
    end else begin
      state_next.div  = state_reg.div + 5'h01;
      state_next.tick = 1'b0;
    end
    // answer only what the host asks; nothing here can start a cycle
    state_next.rsp.valid = acc_i.valid & ~acc_i.write;
    state_next.rsp.rdata = 32'h0000_0000;  // upper lanes carry no port data
    if (acc_i.valid && port_ok) begin
      if (acc_i.write) begin
        // only lane 0 holds port data, whatever the transfer width
        if (acc_i.be[0] && acc_i.space == ESD_SPACE_OUT) begin
          state_next.out[base +: PORT_W] = acc_i.wdata[PORT_W-1:0];
        end
      end else if (acc_i.space == ESD_SPACE_OUT) begin
        state_next.rsp.rdata[PORT_W-1:0] = state_reg.out[base +: PORT_W];
      end else begin
        state_next.rsp.rdata[PORT_W-1:0] = filt[base +: PORT_W];
      end
    end
    // a pin sinks only when set to output and its bit is on
    state_next.oe_n = ~(state_next.out & cfg_i.dir_out);
    // events stay latched whether or not they may interrupt
    state_next.irq = |(pend & cfg_i.irq_en);
  end

  // reset leaves every output released; no strap is sampled
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_reg.div  <= '0;
      state_reg.tick <= 1'b0;
      state_reg.out  <= OUT_RESET;
      state_reg.oe_n <= OE_N_RESET;
      state_reg.rsp  <= '0;
      state_reg.irq  <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  // open drain: the pin only ever pulls low
  assign pin_o      = '0;
  assign pin_oe_n_o = state_reg.oe_n;
  assign rsp_o      = state_reg.rsp;
  assign filt_o     = filt;
  assign pend_o     = pend;
  assign irq_o      = state_reg.irq;

endmodule : esd_top

`default_nettype wire

// ---- sim/esd_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
module esd_properties import esd_pkg::*; (
  // clock and reset
  input wire logic              mclk_i,
  input wire logic              reset_n_i,
  // watched ports
  input wire esd_acc_type       acc_i,
  input wire esd_rsp_type       rsp_o,
  input wire esd_cfg_type       cfg_i,
  input wire logic [NUM_CH-1:0] pend_clr_i,
  input wire logic [NUM_CH-1:0] pin_o,
  input wire logic [NUM_CH-1:0] pin_oe_n_o,
  input wire logic [NUM_CH-1:0] filt_o,
  input wire logic [NUM_CH-1:0] pend_o,
  input wire logic              irq_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);
  // bus answers and pin drive
  chk_read_answer: assert property (acc_i.valid && !acc_i.write |=> rsp_o.valid)
    else $error("read not answered");
  chk_write_silent: assert property (acc_i.valid && acc_i.write |=> !rsp_o.valid)
    else $error("write answered");
  chk_upper_zero: assert property (rsp_o.valid |-> rsp_o.rdata[31:8] == '0)
    else $error("upper lanes not zero");
  chk_oe_dir: assert property (
    (~pin_oe_n_o & ~$past(cfg_i.dir_out)) == '0)
    else $error("input channel sinks");
  chk_pin_low: assert property (pin_o == '0)
    else $error("pin drives high");
  // flags rise only on a filtered edge of the chosen polarity
  chk_pend_edge: assert property (
    ((pend_o & ~$past(pend_o)) & (filt_o ~^ $past(filt_o))) == '0)
    else $error("flag without edge");
  chk_pend_pol: assert property (
    ((pend_o & ~$past(pend_o)) & (filt_o ^ $past(cfg_i.pol_rise))) == '0)
    else $error("flag on wrong edge");
  chk_pend_sticky: assert property (
    (~pend_o & $past(pend_o) & ~$past(pend_clr_i)) == '0)
    else $error("flag lost");
  chk_irq_merge: assert property (irq_o == |$past(pend_o & cfg_i.irq_en))
    else $error("irq wrong");
endmodule : esd_properties
bind esd_top esd_properties esd_properties_i (.mclk_i, .reset_n_i, .acc_i, .rsp_o, .cfg_i,
  .pend_clr_i, .pin_o, .pin_oe_n_o, .filt_o, .pend_o, .irq_o);
`default_nettype wire

// ---- sim/esd_field.sv ----
`timescale 1ns/1ps
`default_nettype none
module esd_field import esd_pkg::*; (
  // far end drive and block outputs
  input wire logic [NUM_CH-1:0] ext_i,
  input wire logic [NUM_CH-1:0] pin_o_i,
  input wire logic [NUM_CH-1:0] oe_n_i,
  // resolved line level
  output logic [NUM_CH-1:0]     wire_o
);
  // pull-up line: any sinking party wins
  assign wire_o = ext_i & (oe_n_i | pin_o_i);
endmodule : esd_field
`default_nettype wire

// ---- sim/esd_top_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module esd_top_tb_top;
  import esd_pkg::*;
  logic              mclk_i = 1'b0;
  logic              reset_n_i = 1'b0;
  esd_acc_type       acc_i = '0;
  esd_rsp_type       rsp_o;
  esd_cfg_type       cfg_i = '0;
  logic [NUM_CH-1:0] pend_clr_i = '0, ext = '0, pin_i, pin_o, pin_oe_n_o, filt_o, pend_o;
  logic              irq_o;
  int                num_errors = 0, check_count = 0, seed = 9823;
  logic [7:0]        b;
  logic [31:0]       rd;
  int                lim;
  initial forever #20 mclk_i = ~mclk_i;
  esd_top esd_top_i (.mclk_i, .reset_n_i, .acc_i, .rsp_o, .cfg_i, .pend_clr_i, .pin_i,
    .pin_o, .pin_oe_n_o, .filt_o, .pend_o, .irq_o);
  esd_field esd_field_i (.ext_i(ext), .pin_o_i(pin_o), .oe_n_i(pin_oe_n_o), .wire_o(pin_i));
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask : cyc
  task automatic check(input string n, input logic [47:0] got, exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", n, exp, got);
    end
  endtask : check
  // one access, then an idle cycle so valid never toggles twice in a step
  task automatic acc(input logic w, input esd_space_type s, input logic [2:0] p,
                     input logic [7:0] d, input logic [3:0] be);
    acc_i = '{1'b1, w, s, p, be, {24'h000000, d}};
    cyc(1);
    rd = rsp_o.valid ? rsp_o.rdata : 32'hFFFF_FFFF;
    acc_i.valid = 1'b0;
    cyc(1);
  endtask : acc
  function automatic logic [7:0] oe_exp(input logic [7:0] d, dir);
    return ~(d & dir);
  endfunction : oe_exp
  // debounce length in ticks for each select code
  function automatic int deb_ticks(input logic [1:0] sel);
    case (sel)
      2'h0:    return int'(DEB_LIM_0);
      2'h1:    return int'(DEB_LIM_1);
      2'h2:    return int'(DEB_LIM_2);
      default: return int'(DEB_LIM_3);
    endcase
  endfunction : deb_ticks
  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : finish_test
  initial begin
    #(70000 * 40);  // longest debounce code dominates the run
    num_errors++;
    finish_test;
  end
  initial begin
    cyc(6);
    reset_n_i = 1'b1;
    check("oe_n", pin_oe_n_o, '1);
    check("rsp idle", rsp_o.valid, 1'b0);
    $display("reset test done");
    // one signal on two channels: ch0 rising with irq, ch1 falling polled
    cfg_i.deb_sel = 2'h1;
    cfg_i.pol_rise = 48'h1;
    cfg_i.irq_en = 48'h1;
    ext[1:0] = 2'h3;
    cyc(100);
    ext[1:0] = 2'h0;
    cyc(300);
    check("glitch", pend_o, 48'h0);
    check("glitch filt", filt_o, 48'h0);
    ext[1:0] = 2'h3;
    cyc(300);
    check("rise", pend_o, 48'h1);
    check("irq", irq_o, 1'b1);
    acc(1'b0, ESD_SPACE_IN, 3'h0, 8'h00, 4'h1);
    check("in", rd, 32'h3);
    ext[1:0] = 2'h0;
    cyc(300);
    check("fall", pend_o, 48'h3);
    pend_clr_i = 48'h1;
    cyc(1);
    pend_clr_i = '0;
    cyc(2);
    check("clear", pend_o, 48'h2);
    check("irq clear", irq_o, 1'b0);
    // every debounce code on ch2: never early, always within one more tick
    for (int s = 0; s < 4; s++) begin
      cfg_i.deb_sel = 2'(s);
      lim = deb_ticks(2'(s));
      ext[2] = 1'b1;
      cyc(2 + DEB_TICK_CYC * (lim - 1));
      check("deb early", filt_o[2], 1'b0);
      cyc(DEB_TICK_CYC + 1);
      check("deb rise", filt_o[2], 1'b1);
      check("no rise event", pend_o[2], 1'b0);
      ext[2] = 1'b0;
      cyc(2 + DEB_TICK_CYC * (lim - 1));
      check("deb hold", filt_o[2], 1'b1);
      cyc(DEB_TICK_CYC + 1);
      check("deb fall", filt_o[2], 1'b0);
      check("fall event", pend_o[2], 1'b1);
      check("polled only", irq_o, 1'b0);
      pend_clr_i[2] = 1'b1;
      cyc(1);
      pend_clr_i[2] = 1'b0;
    end
    check("left", pend_o, 48'h2);
    $display("event test done");
    cfg_i.dir_out = 48'({$random(seed), $random(seed)});
    for (int k = 0; k < 8; k++) begin
      b = 8'($random(seed));
      acc(1'b1, ESD_SPACE_OUT, k[2:0], b, {b[2:0], 1'b1});
      check("write answer", rd, 32'hFFFF_FFFF);
      acc(1'b1, ESD_SPACE_OUT, k[2:0], ~b, 4'hE);
      acc(1'b1, ESD_SPACE_IN, k[2:0], ~b, 4'hF);
      acc(1'b0, ESD_SPACE_OUT, k[2:0], 8'h00, 4'h1);
      check("readback", rd, k < 6 ? b : 8'h00);
      if (k < 6) check("oe_n", pin_oe_n_o[k*8 +: 8], oe_exp(b, cfg_i.dir_out[k*8 +: 8]));
    end
    $display("port test done");
    // drive a whole port, then reset mid-run: every line must let go
    cfg_i.dir_out = '1;
    acc(1'b1, ESD_SPACE_OUT, 3'h0, 8'hFF, 4'h1);
    check("drive", pin_oe_n_o[7:0], 8'h00);
    reset_n_i = 1'b0;
    cyc(1);
    check("reset oe_n", pin_oe_n_o, '1);
    check("reset pend", pend_o, 48'h0);
    reset_n_i = 1'b1;
    cyc(2);
    check("after reset oe_n", pin_oe_n_o, '1);
    check("after reset irq", irq_o, 1'b0);
    acc(1'b0, ESD_SPACE_OUT, 3'h0, 8'h00, 4'h1);
    check("reset readback", rd, 32'h0);
    $display("mid-run reset test done");
    finish_test;
  end
endmodule : esd_top_tb_top
`default_nettype wire
